// >>> hw/pid_xfer_map.svh
// Register offsets, field positions, reset values and limits of the loop
// data path. Assumes inclusion by bare name from the design files.
`ifndef PID_XFER_MAP_SVH
`define PID_XFER_MAP_SVH

// Register byte offsets on the APB slave
`define OFS_SETPOINT      8'h00
`define OFS_PV_WORD       8'h04
`define OFS_CV_WORD       8'h08
`define OFS_PV_SRC        8'h0C
`define OFS_CV_DST        8'h10
`define OFS_CTRL          8'h14
`define OFS_STATUS        8'h18

// Control register fields
`define CTRL_AUTO_BIT     0
`define CTRL_WIDE_BIT     1
`define CTRL_BIPOLAR_BIT  2
`define CTRL_RESET        16'h0000

// Reset values of the loop table words
`define WORD_RESET        16'h0000
`define SEL_OFF           16'h0000

// Data formats and backplane limits
`define NARROW_BITS       12
`define WIDE_BITS         15
`define SLOT_COUNT        8
`define CHAN_COUNT        8

`endif

// >>> hw/pid_xfer_pkg.sv
// Types shared by the loop data path and its backplane transfer port.
// Assumes pid_xfer_map.svh is on the include path.
package pid_xfer_pkg;

  // One backplane request: direction, target slot and channel, write data
  typedef struct packed {
    logic        we;
    logic [2:0]  slot;
    logic [2:0]  chan;
    logic [15:0] wdata;
  } bp_req_t;

  // Decoded slot/channel selection word
  typedef struct packed {
    logic        on;
    logic        ok;
    logic [2:0]  slot;
    logic [2:0]  chan;
  } sel_t;

  // Engine sequence, Gray coded from ST_IDLE through ST_DONE; the step back to ST_IDLE flips two bits
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_PV_RD = 3'b001,
    ST_CALC  = 3'b011,
    ST_CV_WR = 3'b010,
    ST_DONE  = 3'b110
  } eng_state_t;

endpackage

// >>> hw/bp_xfer.sv
// Backplane transfer port: holds one request until the module acknowledges.
// Assumes the analog module pulses bp_ack_i while the request is held.
`timescale 1ns/1ns
`default_nettype none

module bp_xfer
  import pid_xfer_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  input  wire logic        start_i,
  input  wire bp_req_t     req_i,
  input  wire logic        bp_ack_i,
  input  wire logic [15:0] bp_rdata_i,
  output var  logic        bp_valid_o,
  output var  bp_req_t     bp_req_o,
  output var  logic        done_o,
  output var  logic [15:0] rdata_o
);

  // ----------------------------------------------------------------
  // Request hold and completion
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      bp_valid_o <= 1'b0;
      bp_req_o   <= '0;
      done_o     <= 1'b0;
      rdata_o    <= 16'h0000;
    end
    else if (ce_i)
    begin
      done_o <= 1'b0;
      if (bp_valid_o && bp_ack_i)
      begin
        bp_valid_o <= 1'b0;
        done_o     <= 1'b1;
        if (!bp_req_o.we)
          rdata_o <= bp_rdata_i;
      end
      else if (!bp_valid_o && start_i)
      begin
        bp_valid_o <= 1'b1;
        bp_req_o   <= req_i;
      end
    end
  end

endmodule

`default_nettype wire

// >>> hw/pid_loop_analog_autotransfer.sv
// Loop data path: loop table words, direct analog transfer, APB registers.
// Assumes a scheduler pulses calc_start_i once per loop calculation and
// the control equation presents its result on cv_result_i.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pid_xfer_map.svh"

// How it works
// (R1) With transfer enabled, read value and write output exactly once per calculation.
// (R2) Transfers run from the calculation strobe, independent of the ladder scan.
// (R3) One select word picks the value source, another the output destination.
// (R4) Upper digit pair is the slot, lower pair the channel.
// (R5) Slot zero is next to the processor, counting upward away from it.
// (R6) Select word zero skips direct access; the ladder moves that value itself.
// (R7) Output is written in the same data format the value is read in.
// (R8) 12 or 15 bit, unipolar or bipolar, applies to all loop values.
// (R9) Ramp/soak or cascade setpoints are stored into the setpoint word by hardware.
// (R10) Other setpoint sources are written into the setpoint word by software.
// (R11) Manual mode leaves the control output word to outside writers.
// (R12) Automatic mode stores the equation result each sample period.
// (R13) Select digits are BCD; absent slot or channel causes no transfer.
module pid_loop_analog_autotransfer
  import pid_xfer_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output var  logic [31:0] prdata_o,
  output var  logic        pready_o,
  output var  logic        pslverr_o,
  input  wire logic        calc_start_i,
  input  wire logic [15:0] cv_result_i,
  input  wire logic        sp_gen_valid_i,
  input  wire logic [15:0] sp_gen_i,
  input  wire logic [7:0]  slot_present_i,
  output var  logic        calc_done_o,
  output var  logic [15:0] loop_setpoint_o,
  output var  logic [15:0] measured_process_value_o,
  output var  logic        bp_valid_o,
  output var  bp_req_t     bp_req_o,
  input  wire logic        bp_ack_i,
  input  wire logic [15:0] bp_rdata_i
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic sel_t decode_sel(input logic [15:0] w, input logic [7:0] present);
    logic [7:0] slot_bin;
    logic [7:0] chan_bin;
    logic       bcd_ok;
    sel_t       s;
    bcd_ok   = (w[15:12] < 4'd10) && (w[11:8] < 4'd10)
               && (w[7:4] < 4'd10) && (w[3:0] < 4'd10);
    slot_bin = ({4'h0, w[15:12]} * 8'd10) + {4'h0, w[11:8]};  // (R4) (R13)
    chan_bin = ({4'h0, w[7:4]} * 8'd10) + {4'h0, w[3:0]};
    s.on     = (w != `SEL_OFF);                                 // (R6)
    s.slot   = slot_bin[2:0];                                   // (R5)
    s.chan   = 3'(chan_bin - 8'd1);
    s.ok     = s.on && bcd_ok && (slot_bin < 8'(`SLOT_COUNT))
               && present[slot_bin[2:0]]
               && (chan_bin != 8'd0) && (chan_bin <= 8'(`CHAN_COUNT)); // (R13)
    return s;
  endfunction

  function automatic logic [15:0] fit_fmt(input logic [15:0] v, input logic wide,
                                          input logic bipolar);
    logic [15:0] r;
    r = 16'h0000;
    if (wide)
      r = {(bipolar ? v[`WIDE_BITS-1] : 1'b0), v[`WIDE_BITS-1:0]};
    else
      r = {{4{bipolar & v[`NARROW_BITS-1]}}, v[`NARROW_BITS-1:0]};
    return r;                                                   // (R8)
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] setpoint_word_q;
  logic [15:0] pv_word_q;
  logic [15:0] cv_word_q;
  logic [15:0] pv_source_select_q;
  logic [15:0] output_destination_select_q;
  logic [15:0] ctrl_q;
  logic [7:0]  calc_count_q;
  logic        pv_skip_q;
  logic        cv_skip_q;
  eng_state_t  state_q;
  logic        xfer_start_q;
  bp_req_t     xfer_req_q;
  logic        xfer_done;
  logic [15:0] xfer_rdata;
  sel_t        pv_sel;
  sel_t        cv_sel;
  logic        wide;
  logic        bipolar;
  logic        auto_mode;
  logic        apb_wr;
  logic        apb_rd;
  logic        addr_ok;

  assign pv_sel    = decode_sel(pv_source_select_q, slot_present_i);
  assign cv_sel    = decode_sel(output_destination_select_q, slot_present_i);
  assign wide      = ctrl_q[`CTRL_WIDE_BIT];
  assign bipolar   = ctrl_q[`CTRL_BIPOLAR_BIT];
  assign auto_mode = ctrl_q[`CTRL_AUTO_BIT];

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign apb_wr  = psel_i && penable_i && pready_o && pwrite_i;
  assign apb_rd  = psel_i && penable_i && !pready_o && !pwrite_i;
  assign addr_ok = (paddr_i <= `OFS_STATUS) && (paddr_i[1:0] == 2'b00);

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pready_o  <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !addr_ok;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
      prdata_o <= 32'h0000_0000;
    else if (ce_i && apb_rd)
    begin
      case (paddr_i)
        `OFS_SETPOINT: prdata_o <= {16'h0000, setpoint_word_q};
        `OFS_PV_WORD:  prdata_o <= {16'h0000, pv_word_q};
        `OFS_CV_WORD:  prdata_o <= {16'h0000, cv_word_q};
        `OFS_PV_SRC:   prdata_o <= {16'h0000, pv_source_select_q};
        `OFS_CV_DST:   prdata_o <= {16'h0000, output_destination_select_q};
        `OFS_CTRL:     prdata_o <= {16'h0000, ctrl_q};
        `OFS_STATUS:   prdata_o <= {16'h0000, calc_count_q, 3'b000, pv_skip_q,
                                    cv_skip_q, state_q};
        default:       prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration words
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      pv_source_select_q          <= `SEL_OFF;
      output_destination_select_q <= `SEL_OFF;
      ctrl_q                      <= `CTRL_RESET;
    end
    else if (ce_i && apb_wr && !pslverr_o)
    begin
      case (paddr_i)
        `OFS_PV_SRC: pv_source_select_q          <= pwdata_i[15:0]; // (R3)
        `OFS_CV_DST: output_destination_select_q <= pwdata_i[15:0]; // (R3)
        `OFS_CTRL:   ctrl_q                      <= pwdata_i[15:0];
        default:     ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Setpoint word
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
      setpoint_word_q <= `WORD_RESET;
    else if (ce_i)
    begin
      if (sp_gen_valid_i)
        setpoint_word_q <= fit_fmt(sp_gen_i, wide, bipolar);   // (R9)
      else if (apb_wr && paddr_i == `OFS_SETPOINT)
        setpoint_word_q <= pwdata_i[15:0];                     // (R10)
    end
  end

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      state_q      <= ST_IDLE;
      xfer_start_q <= 1'b0;
      xfer_req_q   <= '0;
      pv_skip_q    <= 1'b0;
      cv_skip_q    <= 1'b0;
      calc_done_o  <= 1'b0;
      calc_count_q <= 8'h00;
    end
    else if (ce_i)
    begin
      xfer_start_q <= 1'b0;
      calc_done_o  <= 1'b0;
      case (state_q)
        ST_IDLE:
          if (calc_start_i)                                   // (R1) (R2)
          begin
            pv_skip_q <= pv_sel.on && !pv_sel.ok;
            cv_skip_q <= cv_sel.on && !cv_sel.ok;
            if (pv_sel.ok)
            begin
              xfer_req_q   <= '{we: 1'b0, slot: pv_sel.slot, chan: pv_sel.chan,
                                wdata: 16'h0000};
              xfer_start_q <= 1'b1;
              state_q      <= ST_PV_RD;
            end
            else
              state_q <= ST_CALC;                             // (R6) (R13)
          end
        ST_PV_RD:
          if (xfer_done)
            state_q <= ST_CALC;
        ST_CALC:
          if (cv_sel.ok)
          begin
            xfer_req_q   <= '{we: 1'b1, slot: cv_sel.slot, chan: cv_sel.chan,
                              wdata: auto_mode ? fit_fmt(cv_result_i, wide, bipolar)
                                               : fit_fmt(cv_word_q, wide, bipolar)}; // (R7)
            xfer_start_q <= 1'b1;
            state_q      <= ST_CV_WR;
          end
          else
            state_q <= ST_DONE;
        ST_CV_WR:
          if (xfer_done)
            state_q <= ST_DONE;
        ST_DONE:
        begin
          calc_done_o  <= 1'b1;
          calc_count_q <= calc_count_q + 8'd1;
          state_q      <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Process value and control output words
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
      pv_word_q <= `WORD_RESET;
    else if (ce_i)
    begin
      if (state_q == ST_PV_RD && xfer_done)
        pv_word_q <= fit_fmt(xfer_rdata, wide, bipolar);       // (R1) (R8)
      else if (apb_wr && paddr_i == `OFS_PV_WORD)
        pv_word_q <= pwdata_i[15:0];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
      cv_word_q <= `WORD_RESET;
    else if (ce_i)
    begin
      if (state_q == ST_CALC && auto_mode)
        cv_word_q <= fit_fmt(cv_result_i, wide, bipolar);      // (R12)
      else if (apb_wr && paddr_i == `OFS_CV_WORD && !(state_q == ST_CALC && auto_mode))
        cv_word_q <= pwdata_i[15:0];                           // (R11)
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      loop_setpoint_o          <= `WORD_RESET;
      measured_process_value_o <= `WORD_RESET;
    end
    else if (ce_i)
    begin
      loop_setpoint_o          <= setpoint_word_q;
      measured_process_value_o <= pv_word_q;
    end
  end

  // ----------------------------------------------------------------
  // Backplane port
  // ----------------------------------------------------------------
  bp_xfer u_bp_xfer (
    .mclk_i     (mclk_i),
    .rst_b_i    (rst_b_i),
    .ce_i       (ce_i),
    .start_i    (xfer_start_q),
    .req_i      (xfer_req_q),
    .bp_ack_i   (bp_ack_i),
    .bp_rdata_i (bp_rdata_i),
    .bp_valid_o (bp_valid_o),
    .bp_req_o   (bp_req_o),
    .done_o     (xfer_done),
    .rdata_o    (xfer_rdata)
  );

endmodule

`default_nettype wire

// >>> test/pid_loop_checker_asserts.sv
// Port checker for the loop data path.
// Assumes ce_i stays high while bound.
`timescale 1ns/1ns
`default_nettype none
module pid_loop_checker
  import pid_xfer_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic       psel_i,
  input  wire logic       penable_i,
  input  wire logic       pready_o,
  input  wire logic       pslverr_o,
  input  wire logic       calc_done_o,
  input  wire logic       bp_valid_o,
  input  wire bp_req_t    bp_req_o,
  input  wire logic       bp_ack_i,
  input  wire logic [7:0] slot_present_i
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  // ----
  // Assertions
  // ----
  AST_RST_QUIET: assert property (disable iff (1'b0) !rst_b_i |=> !bp_valid_o && !pready_o)
    else $error("output active after reset");
  AST_PREADY_ONE: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  AST_PREADY_CAUSE: assert property (pready_o |-> psel_i && penable_i && $past(penable_i))
    else $error("pready without access phase");
  AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  AST_REQ_HOLD: assert property (bp_valid_o && !bp_ack_i |=> bp_valid_o && $stable(bp_req_o))
    else $error("request changed before ack");
  AST_REQ_DROP: assert property (bp_valid_o && bp_ack_i |=> !bp_valid_o)
    else $error("request held after ack");
  AST_SLOT_PRESENT: assert property (bp_valid_o |-> slot_present_i[bp_req_o.slot])
    else $error("request to absent slot");
  AST_DONE_ONE: assert property (calc_done_o |=> !calc_done_o)
    else $error("done longer than one cycle");
  AST_WRITE_LAST: assert property (bp_valid_o && bp_req_o.we |-> ##[1:30] calc_done_o)
    else $error("no done after output write");
  cover property (bp_valid_o && bp_ack_i && bp_req_o.we);
  cover property (bp_valid_o && bp_ack_i && !bp_req_o.we);
  cover property (pslverr_o);
endmodule

bind pid_loop_analog_autotransfer pid_loop_checker pid_loop_checker_inst (.mclk_i, .rst_b_i,
  .psel_i, .penable_i, .pready_o, .pslverr_o, .calc_done_o, .bp_valid_o, .bp_req_o,
  .bp_ack_i, .slot_present_i);
`default_nettype wire

// >>> test/analog_module_model.sv
// Analog module rack model on the backplane port.
// Assumes one request held until acked.
`timescale 1ns/1ns
`default_nettype none
module analog_module_model
  import pid_xfer_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic [3:0]  lat_i,
  input  wire logic        bp_valid_i,
  input  wire bp_req_t     bp_req_i,
  output var  logic        bp_ack_o,
  output var  logic [15:0] bp_rdata_o
);
  logic       go;
  logic [3:0] wait_q;
  logic [7:0] rd_cnt_q;
  logic [7:0] wr_cnt_q;
  bp_req_t    rd_q;
  bp_req_t    wr_q;
  assign go = rst_b_i && bp_valid_i && !bp_ack_o && wait_q == lat_i;
  // Ack after lat_i cycles
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i || !bp_valid_i || bp_ack_o)
    begin
      wait_q   <= 4'h0;
      bp_ack_o <= 1'b0;
    end
    else if (go)
      bp_ack_o <= 1'b1;
    else
      wait_q <= wait_q + 4'h1;
  end
  // Read data only with ack, toggling otherwise
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
      bp_rdata_o <= 16'h5A5A;
    else if (go)
      bp_rdata_o <= {4'hC, 1'b1, bp_req_i.slot, bp_req_i.chan, 5'h05};
    else
      bp_rdata_o <= ~bp_rdata_o;
  end
  // Transfer log
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      rd_cnt_q <= 8'h00;
      wr_cnt_q <= 8'h00;
    end
    else if (go && bp_req_i.we)
    begin
      wr_cnt_q <= wr_cnt_q + 8'h01;
      wr_q     <= bp_req_i;
    end
    else if (go)
    begin
      rd_cnt_q <= rd_cnt_q + 8'h01;
      rd_q     <= bp_req_i;
    end
  end
endmodule
`default_nettype wire

// >>> test/tb_pid_loop_analog_autotransfer.sv
// Testbench for the loop data path.
// Assumes the analog module model and bound checker.
`timescale 1ns/1ns
`default_nettype none
`include "pid_xfer_map.svh"
module tb_pid_loop_analog_autotransfer
  import pid_xfer_pkg::*;
;
  logic        mclk_i = 1'b0, rst_b_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic        pwrite_i = 1'b0, calc_start_i = 1'b0, sp_gen_valid_i = 1'b0, err;
  logic [7:0]  paddr_i = 8'h00, slot_present_i = 8'hFF, nrd, nwr, ncalc = 8'h00;
  logic [15:0] cv_result_i = 16'h0000, sp_gen_i = 16'h0000, bp_rdata_i;
  logic [15:0] loop_setpoint_o, measured_process_value_o;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd;
  logic        pready_o, pslverr_o, calc_done_o, bp_valid_o, bp_ack_i;
  logic [3:0]  lat = 4'h0;
  bp_req_t     bp_req_o;
  bp_req_t     rq, wq;
  logic [7:0]  rdc, wrc;
  int          n_fail = 0, total_checks = 0;

  pid_loop_analog_autotransfer pid_loop_analog_autotransfer_inst (.mclk_i, .rst_b_i,
    .ce_i(1'b1), .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .calc_start_i, .cv_result_i, .sp_gen_valid_i, .sp_gen_i, .slot_present_i,
    .calc_done_o, .loop_setpoint_o, .measured_process_value_o, .bp_valid_o, .bp_req_o,
    .bp_ack_i, .bp_rdata_i);
  analog_module_model analog_module_model_inst (.mclk_i, .rst_b_i, .lat_i(lat),
    .bp_valid_i(bp_valid_o), .bp_req_i(bp_req_o), .bp_ack_o(bp_ack_i),
    .bp_rdata_o(bp_rdata_i));
  // Model transfer log
  assign rq  = analog_module_model_inst.rd_q;
  assign wq  = analog_module_model_inst.wr_q;
  assign rdc = analog_module_model_inst.rd_cnt_q;
  assign wrc = analog_module_model_inst.wr_cnt_q;

  initial
  begin
    forever #25 mclk_i = ~mclk_i;
  end
  // ----
  // Tasks
  // ----
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= {16'h0000, d};
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 50);
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    check("apb ready", {31'h0, pready_o}, 32'h0000_0001);
    @(posedge mclk_i);
  endtask
  task automatic calc(input logic [15:0] cv);
    int n;
    n = 0;
    nrd = rdc;
    nwr = wrc;
    cv_result_i  <= cv;
    calc_start_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    calc_start_i <= 1'b0;
    while (calc_done_o !== 1'b1 && n < 200)
    begin
      @(posedge mclk_i);
      n++;
    end
    check("calc done", {31'h0, calc_done_o}, 32'h0000_0001);
    ncalc++;
    @(posedge mclk_i);
  endtask
  function automatic logic [15:0] fit(input logic [15:0] v, input logic w, input logic b);
    if (w)
      return b ? {v[14], v[14:0]} : {1'b0, v[14:0]};
    return b ? {{4{v[11]}}, v[11:0]} : {4'h0, v[11:0]};
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial
  begin
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    for (int a = 0; a <= 24; a += 4)
    begin
      apb(1'b0, 8'(a), 16'h0000);
      check("reset word", rd, 32'h0000_0000);
    end
    apb(1'b0, 8'h1C, 16'h0000);
    check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, `OFS_SETPOINT, 16'h0321);
    apb(1'b0, `OFS_SETPOINT, 16'h0000);
    check("setpoint", rd, 32'h0000_0321);
    sp_gen_i       <= 16'hF456;
    sp_gen_valid_i <= 1'b1;
    @(posedge mclk_i);
    sp_gen_valid_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    check("setpoint port", {16'h0000, loop_setpoint_o}, 32'h0000_0456);
    apb(1'b1, `OFS_PV_SRC, 16'h0102);
    apb(1'b1, `OFS_CV_DST, 16'h0305);
    for (int f = 0; f < 4; f++)
    begin
      lat <= 4'(f * 3);
      apb(1'b1, `OFS_CTRL, {13'h0000, f[1], f[0], 1'b1});
      calc(16'h5ABC);
      check("pv reads", {24'h0, rdc}, {24'h0, nrd + 8'h01});
      check("cv writes", {24'h0, wrc}, {24'h0, nwr + 8'h01});
      check("pv place", {26'h0, rq.slot, rq.chan}, 32'h0000_0009);
      check("cv place", {26'h0, wq.slot, wq.chan}, 32'h0000_001C);
      check("cv data", {16'h0, wq.wdata}, {16'h0, fit(16'h5ABC, f[0], f[1])});
      apb(1'b0, `OFS_PV_WORD, 16'h0000);
      check("pv word", rd, {16'h0, fit(16'hC925, f[0], f[1])});
      check("pv port", {16'h0, measured_process_value_o}, {16'h0, fit(16'hC925, f[0], f[1])});
    end
    apb(1'b1, `OFS_PV_SRC, 16'h0000);
    apb(1'b1, `OFS_CV_DST, 16'h0000);
    calc(16'h1111);
    check("zero select", {16'h0, rdc, wrc}, {16'h0, nrd, nwr});
    apb(1'b0, `OFS_CV_WORD, 16'h0000);
    check("auto cv word", rd, 32'h0000_1111);
    slot_present_i <= 8'hFD;
    apb(1'b1, `OFS_PV_SRC, 16'h0102);
    apb(1'b1, `OFS_CV_DST, 16'h010A);
    calc(16'h1111);
    check("bad select", {16'h0, rdc, wrc}, {16'h0, nrd, nwr});
    apb(1'b0, `OFS_STATUS, 16'h0000);
    check("status", {rd[15:8], rd[4:0]}, {ncalc, 5'b11000});
    slot_present_i <= 8'hFF;
    apb(1'b1, `OFS_CTRL, 16'h0000);
    apb(1'b1, `OFS_CV_DST, 16'h0305);
    apb(1'b1, `OFS_CV_WORD, 16'h0123);
    calc(16'h0FFF);
    check("manual out", {16'h0, wq.wdata}, 32'h0000_0123);
    apb(1'b0, `OFS_CV_WORD, 16'h0000);
    check("manual word", rd, 32'h0000_0123);
    results();
  end
  initial
  begin
    repeat (5000) @(posedge mclk_i);
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
